/* rtl/gpd_consts.vh */
// Constants for the general-purpose port data and control block
// Summary of operation
// - Output-mode pin drives its data bit
// - Read returns data bit or pin level
// - Direction mixes per bit in one read
// - Reset clears port 2, 3, 4 data
// - Write reaches pins one cycle later
// - Read samples pins at answer edge
// - Data registers are 4-bit read/write
// - Port 2 pin controls at 10H-13H
// - Port 2 controls are write-only
// - Control bit 3 enables pin interrupt
// - Control bit 2 selects sampling clock
// - Control bit 1 sets pin direction
// - Input: bit 0 pulled or high-impedance
// - Output: bit 0 CMOS or open-drain
// - Every port bit has own direction
// - One global pull polarity bit
// - Port 2 level change raises interrupt request
`ifndef GPD_CONSTS_VH
`define GPD_CONSTS_VH
// Register indices; byte address is four times the index
`define GPD_IDX_P2_DATA   8'h00
`define GPD_IDX_P3_DATA   8'h01
`define GPD_IDX_P4_DATA   8'h02
`define GPD_IDX_P2_CTL0   8'h10
`define GPD_IDX_P2_CTL1   8'h11
`define GPD_IDX_P2_CTL2   8'h12
`define GPD_IDX_P2_CTL3   8'h13
`define GPD_IDX_P34_DIR   8'h20
`define GPD_IDX_P34_DRV   8'h21
`define GPD_IDX_PULL_POL  8'h22
`define GPD_IDX_IRQ_STAT  8'h23
`define GPD_IDX_IRQ_MASK  8'h24
// Control register fields
`define GPD_CTL_DRV       0
`define GPD_CTL_DIR       1
`define GPD_CTL_CLKSEL    2
`define GPD_CTL_IE        3
// Reset values
`define GPD_RST_NIB       4'h0
`define GPD_RST_CTL       16'h0000
`define GPD_RST_BYTE      8'h00
// Sampling clock timing
`define GPD_PCLK_HZ       250000000
`define GPD_SAMPLE_HZ     64
`endif

/* rtl/gpd_port.v */
// Port 2/3/4 data registers, port 2 pin controls and pin-change interrupts
`timescale 1ns/1ns
`include "gpd_consts.vh"

module gpd_port #(
	parameter SAMPLE_DIV = `GPD_PCLK_HZ / `GPD_SAMPLE_HZ
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire [3:0]  p2_in,
	output reg  [3:0]  p2_out,
	output reg  [3:0]  p2_oe_n,
	output reg  [3:0]  p2_pull_en,
	input  wire [3:0]  p3_in,
	output reg  [3:0]  p3_out,
	output reg  [3:0]  p3_oe_n,
	output reg  [3:0]  p3_pull_en,
	input  wire [3:0]  p4_in,
	output reg  [3:0]  p4_out,
	output reg  [3:0]  p4_oe_n,
	output reg  [3:0]  p4_pull_en,
	output reg         pull_up,
	output reg         irq
);

	////////////////////////////////////////////////////////////////////////
	// Pin driver helpers

	// Low while the pad drives; open-drain only drives a zero
	function [3:0] oe_n_of;
		input [3:0] dir;
		input [3:0] drv;
		input [3:0] data;
		begin
			oe_n_of = ~(dir & (~drv | ~data));
		end
	endfunction

	// Mixed read: stored bit for outputs, pin level for inputs
	function [3:0] read_mix;
		input [3:0] dir;
		input [3:0] data;
		input [3:0] pin;
		begin
			read_mix = (dir & data) | (~dir & pin);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Registers

	reg  [3:0]  p2_data_q;
	reg  [3:0]  p3_data_q;
	reg  [3:0]  p4_data_q;
	reg  [15:0] p2_ctl_q;
	reg  [7:0]  p34_dir_q;
	reg  [7:0]  p34_drv_q;
	reg         pull_pol_q;
	reg  [3:0]  irq_stat_q;
	reg  [3:0]  irq_mask_q;
	reg  [3:0]  samp_q;
	reg  [31:0] div_q;
	reg         tick_q;

	wire [7:0]  idx       = paddr[9:2];
	wire        access    = psel & penable;
	wire        done      = access & pready;
	wire        wr_en     = done & pwrite;
	wire [3:0]  wnib      = pwdata[3:0];
	wire [3:0]  p2_dir;
	wire [3:0]  p2_drv;
	wire [3:0]  p2_ie;
	wire [3:0]  p2_csel;
	reg  [3:0]  p2_samp_en;
	reg  [3:0]  chg;
	reg  [31:0] rd_d;
	reg         hit_d;
	integer     i;

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_ctl
			// Control bit fields per pin
			assign p2_drv[g]  = p2_ctl_q[4*g + `GPD_CTL_DRV];
			assign p2_dir[g]  = p2_ctl_q[4*g + `GPD_CTL_DIR];
			assign p2_csel[g] = p2_ctl_q[4*g + `GPD_CTL_CLKSEL];
			assign p2_ie[g]   = p2_ctl_q[4*g + `GPD_CTL_IE];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Register writes

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p2_data_q  <= `GPD_RST_NIB;
			p3_data_q  <= `GPD_RST_NIB;
			p4_data_q  <= `GPD_RST_NIB;
			p2_ctl_q   <= `GPD_RST_CTL;
			p34_dir_q  <= `GPD_RST_BYTE;
			p34_drv_q  <= `GPD_RST_BYTE;
			pull_pol_q <= 1'b0;
			irq_mask_q <= `GPD_RST_NIB;
		end else if (wr_en) begin
			case (idx)
				`GPD_IDX_P2_DATA: p2_data_q <= wnib;
				`GPD_IDX_P3_DATA: p3_data_q <= wnib;
				`GPD_IDX_P4_DATA: p4_data_q <= wnib;
				`GPD_IDX_P2_CTL0: p2_ctl_q[3:0]   <= wnib;
				`GPD_IDX_P2_CTL1: p2_ctl_q[7:4]   <= wnib;
				`GPD_IDX_P2_CTL2: p2_ctl_q[11:8]  <= wnib;
				`GPD_IDX_P2_CTL3: p2_ctl_q[15:12] <= wnib;
				`GPD_IDX_P34_DIR: p34_dir_q <= pwdata[7:0];
				`GPD_IDX_P34_DRV: p34_drv_q <= pwdata[7:0];
				`GPD_IDX_PULL_POL: pull_pol_q <= pwdata[0];
				`GPD_IDX_IRQ_MASK: irq_mask_q <= wnib;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB answer: one wait state, data and error registered

	always @* begin
		hit_d = 1'b1;
		rd_d  = 32'h0000_0000;
		case (idx)
			`GPD_IDX_P2_DATA: rd_d[3:0] = read_mix(p2_dir, p2_data_q, p2_in);
			`GPD_IDX_P3_DATA: rd_d[3:0] = read_mix(p34_dir_q[3:0], p3_data_q, p3_in);
			`GPD_IDX_P4_DATA: rd_d[3:0] = read_mix(p34_dir_q[7:4], p4_data_q, p4_in);
			`GPD_IDX_P2_CTL0: rd_d = 32'h0000_0000;
			`GPD_IDX_P2_CTL1: rd_d = 32'h0000_0000;
			`GPD_IDX_P2_CTL2: rd_d = 32'h0000_0000;
			`GPD_IDX_P2_CTL3: rd_d = 32'h0000_0000;
			`GPD_IDX_P34_DIR: rd_d[7:0] = p34_dir_q;
			`GPD_IDX_P34_DRV: rd_d[7:0] = p34_drv_q;
			`GPD_IDX_PULL_POL: rd_d[0] = pull_pol_q;
			`GPD_IDX_IRQ_STAT: rd_d[3:0] = irq_stat_q;
			`GPD_IDX_IRQ_MASK: rd_d[3:0] = irq_mask_q;
			default: hit_d = 1'b0;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (access && !pready) begin
			pready  <= 1'b1;
			pslverr <= ~hit_d;
			// Pins sampled here for the read
			prdata  <= pwrite ? 32'h0000_0000 : rd_d;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drivers, registered so pads change one cycle after the write

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p2_out     <= `GPD_RST_NIB;
			p3_out     <= `GPD_RST_NIB;
			p4_out     <= `GPD_RST_NIB;
			p2_oe_n    <= 4'hf;
			p3_oe_n    <= 4'hf;
			p4_oe_n    <= 4'hf;
			p2_pull_en <= 4'hf;
			p3_pull_en <= 4'hf;
			p4_pull_en <= 4'hf;
			pull_up    <= 1'b1;
		end else begin
			p2_out  <= p2_data_q & p2_dir;
			p3_out  <= p3_data_q & p34_dir_q[3:0];
			p4_out  <= p4_data_q & p34_dir_q[7:4];
			p2_oe_n <= oe_n_of(p2_dir, p2_drv, p2_data_q);
			p3_oe_n <= oe_n_of(p34_dir_q[3:0], p34_drv_q[3:0], p3_data_q);
			p4_oe_n <= oe_n_of(p34_dir_q[7:4], p34_drv_q[7:4], p4_data_q);
			p2_pull_en <= ~p2_dir & ~p2_drv;
			p3_pull_en <= ~p34_dir_q[3:0] & ~p34_drv_q[3:0];
			p4_pull_en <= ~p34_dir_q[7:4] & ~p34_drv_q[7:4];
			pull_up <= ~pull_pol_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin-change interrupts on port 2

	// Slow tick stands in for the 64 Hz time base; shorten SAMPLE_DIV in simulation
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q  <= 32'h0000_0000;
			tick_q <= 1'b0;
		end else if (div_q >= SAMPLE_DIV - 1) begin
			div_q  <= 32'h0000_0000;
			tick_q <= 1'b1;
		end else begin
			div_q  <= div_q + 32'h0000_0001;
			tick_q <= 1'b0;
		end
	end

	always @* begin
		for (i = 0; i < 4; i = i + 1) begin
			p2_samp_en[i] = p2_csel[i] | tick_q;
			chg[i] = p2_samp_en[i] & p2_ie[i] & (p2_in[i] != samp_q[i]);
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			samp_q     <= `GPD_RST_NIB;
			irq_stat_q <= `GPD_RST_NIB;
			irq        <= 1'b0;
		end else begin
			for (i = 0; i < 4; i = i + 1) begin
				if (p2_samp_en[i])
					samp_q[i] <= p2_in[i];
			end
			if (wr_en && idx == `GPD_IDX_IRQ_STAT)
				irq_stat_q <= (irq_stat_q & ~wnib) | chg;
			else
				irq_stat_q <= irq_stat_q | chg;
			irq <= |(irq_stat_q & irq_mask_q);
		end
	end

endmodule // gpd_port

/* sim/gpd_port_assertions.sv */
// Bus and pad checks for the port block
`timescale 1ns/1ns
module gpd_port_chk #(parameter SAMPLE_DIV = 8) (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire [3:0]  p2_out,
	input wire [3:0]  p2_oe_n,
	input wire [3:0]  p2_pull_en,
	input wire        irq
);
	wire [7:0]  ix = paddr[9:2];
	wire        ctl = ix[7:2] == 6'h04;
	wire        bad = !(ix < 8'h03 || ctl || (ix > 8'h1f && ix < 8'h25));
	wire [11:0] pads = {p2_out, p2_oe_n, p2_pull_en};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_acc;
		psel && !penable ##1 psel && penable;
	endsequence
	chk_ready_wait: assert property (s_acc |-> !pready ##1 pready)
		else $error("pready late");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held");
	chk_err_map: assert property (s_acc |=> pslverr == bad)
		else $error("pslverr wrong");
	chk_ctl_readzero: assert property (s_acc ##0 !pwrite && ctl |=> prdata == 32'h0)
		else $error("control read back");
	chk_pad_nopull: assert property (((p2_out | ~p2_oe_n) & p2_pull_en) == 4'h0)
		else $error("driven pin pulled");
	chk_pad_after_wr: assert property (!$stable(pads) |-> $past(pready, 2) && $past(pwrite, 2))
		else $error("pad moved without write");
	chk_irq_fall: assert property ($fell(irq) |-> $past(pready, 2) && $past(pwrite, 2))
		else $error("irq dropped without write");
	chk_reset_outs: assert property (!$past(presetn) |-> pads == 12'h0ff && !irq)
		else $error("outputs not at reset");
endmodule // gpd_port_chk

bind gpd_port gpd_port_chk #(.SAMPLE_DIV(SAMPLE_DIV)) u_chk (.*);

/* sim/gpd_pins.sv */
// Equipment wired to one 4-bit port
`timescale 1ns/1ns
module gpd_pins (
	input  wire [3:0] o,
	input  wire [3:0] oe_n,
	input  wire [3:0] xv,
	output wire [3:0] lv
);
	// driven pad wins
	// Equipment drives every released pin, so no read can see a stale float
	assign lv = ~oe_n & o | oe_n & xv;
endmodule // gpd_pins

/* sim/gpd_port_tb.sv */
// Self-checking bench for the port block
`timescale 1ns/1ns
module gpd_port_tb;
	reg         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	reg  [11:0] paddr = 12'h0;
	reg  [31:0] pwdata = 32'h0, rd;
	reg  [3:0]  p3_in = 4'h0, xv2 = 4'hf, xv4 = 4'h0, dir, dat;
	reg         err;
	wire [31:0] prdata;
	wire        pready, pslverr, pull_up, irq;
	wire [3:0]  p2_in, p2_out, p2_oe_n, p2_pull_en, p3_out, p3_oe_n, p3_pull_en;
	wire [3:0]  p4_in, p4_out, p4_oe_n, p4_pull_en;
	integer     failures = 0, samples_checked = 0, i, n;
	always #2 pclk = ~pclk;
	gpd_port #(.SAMPLE_DIV(8)) u_dut (.*);
	gpd_pins u_p2 (.o(p2_out), .oe_n(p2_oe_n), .xv(xv2), .lv(p2_in));
	gpd_pins u_p4 (.o(p4_out), .oe_n(p4_oe_n), .xv(xv4), .lv(p4_in));
	task chk(input [31:0] seen, input [31:0] exp);
		samples_checked = samples_checked + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Request held until pready is sampled high
	task apb(input w, input [7:0] ix, input [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b0, ix, 2'b0};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Look mid-cycle so the answer is read while it stands, never in its launch step
		do @(negedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task tick(input integer c);
		repeat (c) @(posedge pclk);
		#1;
	endtask
	task conclude;
		$display("Checks %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#60000;
		failures = failures + 1;
		conclude;
	end
	////////////////////////////////////////
	initial begin
		n = $urandom(32'haa185793);
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1, 8'h20, 32'hf0);
		apb(0, 8'h02, 0);
		chk(rd, 0);
		for (i = 0; i < 8; i = i + 1) begin
			dir = $urandom;
			dat = $urandom;
			xv4 <= $urandom;
			p3_in <= $urandom;
			apb(1, 8'h20, {dir, 4'h0});
			// Upper bus bits are junk the register must drop
			apb(1, 8'h02, $urandom << 4 | dat);
			tick(1);
			chk(p4_out, dat & dir);
			apb(0, 8'h02, 0);
			chk(rd, dat & dir | xv4 & ~dir);
			apb(0, 8'h01, 0);
			chk(rd, p3_in);
		end
		chk({p3_out, p3_oe_n, p3_pull_en}, 12'h0ff);
		apb(1, 8'h20, 32'hf0);
		apb(1, 8'h21, 32'hf0);
		apb(1, 8'h02, 32'h5);
		tick(1);
		chk(p4_oe_n, 4'h5);
		apb(1, 8'h00, 32'hf);
		apb(1, 8'h22, 32'h1);
		tick(1);
		chk(pull_up, 0);
		for (i = 0; i < 4; i = i + 1) begin
			dat = i;
			apb(1, 8'h10 | i[1:0], dat);
			tick(1);
			chk({p2_out[i], p2_oe_n[i], p2_pull_en[i]},
				{dat[1], ~dat[1] | dat[0], ~dat[1] & ~dat[0]});
			apb(0, 8'h10 | i[1:0], 0);
			chk(rd | err, 0);
		end
		apb(0, 8'h30, 0);
		chk(err, 1);
		apb(1, 8'h11, 32'hc);
		apb(1, 8'h12, 32'h8);
		apb(1, 8'h24, 32'h2);
		apb(1, 8'h23, 32'hf);
		xv2 <= 4'h9;
		tick(3);
		chk(irq, 1);
		tick(20);
		apb(0, 8'h23, 0);
		chk(rd, 6);
		apb(1, 8'h23, 32'h2);
		tick(1);
		chk(irq, 0);
		conclude;
	end
endmodule // gpd_port_tb
